// File: rtl/iox_pkg.sv
// package of constants for the sixteen-bit i2c expander
package iox_pkg;
   localparam logic [4:0] IOX_ADDR_BASE = 5'h1d;
   localparam logic [2:0] IOX_REG_PIN0 = 3'h0;
   localparam logic [2:0] IOX_REG_PIN1 = 3'h1;
   localparam logic [2:0] IOX_REG_DRV0 = 3'h2;
   localparam logic [2:0] IOX_REG_DRV1 = 3'h3;
   localparam logic [2:0] IOX_REG_INV0 = 3'h4;
   localparam logic [2:0] IOX_REG_INV1 = 3'h5;
   localparam logic [2:0] IOX_REG_DIR0 = 3'h6;
   localparam logic [2:0] IOX_REG_DIR1 = 3'h7;
   localparam logic [7:0] IOX_DRV_RESET = 8'hff;
   localparam logic [7:0] IOX_INV_RESET = 8'h00;
   localparam logic [7:0] IOX_DIR_RESET = 8'hff;
   localparam logic [7:0] IOX_PTR_RESET = 8'h00;
   localparam int IOX_SEL_LSB = 0;
   localparam int IOX_SEL_MSB = 2;
   localparam logic [3:0] IOX_BITS_LAST = 4'h7;
   localparam logic [3:0] IOX_BITS_ACK = 4'h8;
   typedef enum logic [2:0] {
      IOX_IDLE = 3'b000,
      IOX_ADDR = 3'b001,
      IOX_CMD = 3'b010,
      IOX_WDATA = 3'b011,
      IOX_RDATA = 3'b100
   } iox_state_t;
endpackage

// File: rtl/iox_bus_if.sv
// carrier between the serial engine and the register file
`timescale 1ns/100ps
interface iox_bus_if;
   logic wr_stb;
   logic [2:0] wr_sel;
   logic [7:0] wr_data;
   logic [2:0] rd_sel;
   logic [7:0] rd_data;
   modport engine (output wr_stb, output wr_sel, output wr_data, output rd_sel, input rd_data);
   modport regs (input wr_stb, input wr_sel, input wr_data, input rd_sel, output rd_data);
endinterface

// File: rtl/iox_regs.sv
// register file and pin drivers of the expander
`timescale 1ns/100ps
module iox_regs
   import iox_pkg::*;
(
   // clock and reset
   input wire logic clock,
   input wire logic arst_n,
   // engine side
   iox_bus_if.regs bus,
   // port pins
   input wire logic [15:0] gpio_pin_in,
   output logic [15:0] gpio_pin_out,
   output logic [15:0] gpio_pin_oe
);
   logic [7:0] drive_level_port0, drive_level_port1;
   logic [7:0] invert_select_port0, invert_select_port1;
   logic [7:0] direction_port0, direction_port1;
   logic [7:0] next_drv0, next_drv1, next_inv0, next_inv1, next_dir0, next_dir1;

   // write decode; input port codes fall through untouched
   always_comb begin
      next_drv0 = drive_level_port0;
      next_drv1 = drive_level_port1;
      next_inv0 = invert_select_port0;
      next_inv1 = invert_select_port1;
      next_dir0 = direction_port0;
      next_dir1 = direction_port1;
      if (bus.wr_stb) begin
         unique case (bus.wr_sel)
            IOX_REG_DRV0: next_drv0 = bus.wr_data;
            IOX_REG_DRV1: next_drv1 = bus.wr_data;
            IOX_REG_INV0: next_inv0 = bus.wr_data;
            IOX_REG_INV1: next_inv1 = bus.wr_data;
            IOX_REG_DIR0: next_dir0 = bus.wr_data;
            IOX_REG_DIR1: next_dir1 = bus.wr_data;
            IOX_REG_PIN0, IOX_REG_PIN1: begin
            end
         endcase
      end
   end

   // storage, loaded with defaults under reset
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         drive_level_port0 <= IOX_DRV_RESET;
         drive_level_port1 <= IOX_DRV_RESET;
         invert_select_port0 <= IOX_INV_RESET;
         invert_select_port1 <= IOX_INV_RESET;
         direction_port0 <= IOX_DIR_RESET;
         direction_port1 <= IOX_DIR_RESET;
      end else begin
         drive_level_port0 <= next_drv0;
         drive_level_port1 <= next_drv1;
         invert_select_port0 <= next_inv0;
         invert_select_port1 <= next_inv1;
         direction_port0 <= next_dir0;
         direction_port1 <= next_dir1;
      end
   end

   // pin drive: a one in direction releases the driver
   assign gpio_pin_out = {drive_level_port1, drive_level_port0};
   assign gpio_pin_oe = ~{direction_port1, direction_port0};

   // read mux; pin levels read live, drive levels read from flops
   always_comb begin
      unique case (bus.rd_sel)
         IOX_REG_PIN0: bus.rd_data = gpio_pin_in[7:0] ^ invert_select_port0;
         IOX_REG_PIN1: bus.rd_data = gpio_pin_in[15:8] ^ invert_select_port1;
         IOX_REG_DRV0: bus.rd_data = drive_level_port0;
         IOX_REG_DRV1: bus.rd_data = drive_level_port1;
         IOX_REG_INV0: bus.rd_data = invert_select_port0;
         IOX_REG_INV1: bus.rd_data = invert_select_port1;
         IOX_REG_DIR0: bus.rd_data = direction_port0;
         IOX_REG_DIR1: bus.rd_data = direction_port1;
      endcase
   end
endmodule // iox_regs

// File: rtl/iox_top.sv
// i2c slave engine and top of the sixteen-bit expander
// Operation
// - respond to address 0x74 plus strap pins
// - last address bit one reads, zero writes
// - first write byte loads the pointer
// - three bits select one of eight registers
// - reads use stored pointer, no command
// - pointer persists until next command byte or repeated start
// - pointer writable over bus, not readable
// - input registers return live pin levels
// - writes to input registers are discarded
// - drive registers set outputs, reset ones
// - drive register reads return flop contents
// - invert bits flip reported inputs, reset zero
// - direction one input, zero output, reset ones
// - multi-byte read alternates within pair
// - repeated start re-points to next register in line: pair partner after a data byte
// - data captured at acknowledge clock rise
`timescale 1ns/100ps
module iox_top
   import iox_pkg::*;
(
   // clock and reset
   input wire logic clock,
   input wire logic arst_n,
   // address straps
   input wire logic addr_strap_low,
   input wire logic addr_strap_high,
   // serial bus, sampled synchronously
   input wire logic scl_in,
   input wire logic sda_in,
   output logic sda_out,
   output logic sda_oe,
   // port pins
   input wire logic [15:0] gpio_pin_in,
   output logic [15:0] gpio_pin_out,
   output logic [15:0] gpio_pin_oe
);
   iox_bus_if bus ();

   iox_regs i_iox_regs (
      .clock(clock),
      .arst_n(arst_n),
      .bus(bus),
      .gpio_pin_in(gpio_pin_in),
      .gpio_pin_out(gpio_pin_out),
      .gpio_pin_oe(gpio_pin_oe)
   );

   iox_state_t state, next_state;
   logic scl_q, sda_q, next_scl_q, next_sda_q;
   logic [7:0] shift, next_shift;
   logic [3:0] bit_cnt, next_bit_cnt;
   logic [7:0] register_pointer, next_pointer;
   logic [2:0] cur_sel, next_cur_sel;
   logic [7:0] tx_byte, next_tx_byte;
   logic ack_drive, next_ack_drive;
   logic tx_drive, next_tx_drive;
   logic master_nack, next_master_nack;
   logic wr_stb_c;
   logic [7:0] wr_data_c;

   // bus events from one-cycle-old line samples
   logic scl_rise, scl_fall, start_cond, stop_cond;
   assign scl_rise = scl_in & ~scl_q;
   assign scl_fall = ~scl_in & scl_q;
   assign start_cond = scl_in & scl_q & sda_q & ~sda_in;
   assign stop_cond = scl_in & scl_q & ~sda_q & sda_in;

   // our address: fixed upper bits plus the straps
   function automatic logic addr_match(input logic [6:0] a, input logic s1, input logic s0);
      addr_match = (a == {IOX_ADDR_BASE, s1, s0});
   endfunction

   // pointer select is only the low three bits
   function automatic logic [2:0] sel_of(input logic [7:0] p);
      sel_of = p[IOX_SEL_MSB:IOX_SEL_LSB];
   endfunction

   assign bus.wr_stb = wr_stb_c;
   assign bus.wr_sel = cur_sel;
   assign bus.wr_data = wr_data_c;
   // a read's first byte is fetched while the select still follows the pointer
   assign bus.rd_sel = (state == IOX_ADDR) ? sel_of(register_pointer) : cur_sel;

   // engine next state
   always_comb begin
      next_state = state;
      next_scl_q = scl_in;
      next_sda_q = sda_in;
      next_shift = shift;
      next_bit_cnt = bit_cnt;
      next_pointer = register_pointer;
      next_cur_sel = cur_sel;
      next_tx_byte = tx_byte;
      next_ack_drive = ack_drive;
      next_tx_drive = tx_drive;
      next_master_nack = master_nack;
      wr_stb_c = 1'b0;
      wr_data_c = shift;
      if (stop_cond) begin
         next_state = IOX_IDLE;
         next_ack_drive = 1'b0;
         next_tx_drive = 1'b0;
      end else if (start_cond) begin
         // repeated start re-points to cur_sel, the pair partner of the last register once a data byte has passed
         if (state != IOX_IDLE) begin
            next_pointer = {register_pointer[7:3], cur_sel};
         end
         next_state = IOX_ADDR;
         // the scl fall that closes the start wraps this to zero, so it is not taken as a bit
         next_bit_cnt = 4'hf;
         next_ack_drive = 1'b0;
         next_tx_drive = 1'b0;
      end else if (state != IOX_IDLE) begin
         if (scl_rise) begin
            if (bit_cnt <= IOX_BITS_LAST) begin
               next_shift = {shift[6:0], sda_in};
            end else if (state == IOX_RDATA) begin
               next_master_nack = sda_in;
            end else if (state == IOX_CMD) begin
               next_pointer = shift;
               next_cur_sel = sel_of(shift);
            end else if (state == IOX_WDATA) begin
               wr_stb_c = 1'b1;
               // pair partner takes the next byte
               next_cur_sel = {cur_sel[2:1], ~cur_sel[0]};
            end
         end
         if (scl_fall) begin
            next_bit_cnt = (bit_cnt == IOX_BITS_ACK) ? 4'h0 : bit_cnt + 4'h1;
            next_ack_drive = 1'b0;
            next_tx_drive = 1'b0;
            unique case (state)
               IOX_ADDR: begin
                  if (bit_cnt == IOX_BITS_LAST) begin
                     if (addr_match(shift[7:1], addr_strap_high, addr_strap_low)) begin
                        next_ack_drive = 1'b1;
                     end else begin
                        next_state = IOX_IDLE;
                     end
                  end else if (bit_cnt == IOX_BITS_ACK) begin
                     if (shift[0]) begin
                        next_state = IOX_RDATA;
                        next_cur_sel = sel_of(register_pointer);
                        next_master_nack = 1'b0;
                        next_tx_byte = bus.rd_data;
                        next_tx_drive = 1'b1;
                     end else begin
                        next_state = IOX_CMD;
                     end
                  end
               end
               IOX_CMD, IOX_WDATA: begin
                  if (bit_cnt == IOX_BITS_LAST) begin
                     next_ack_drive = 1'b1;
                  end else if (bit_cnt == IOX_BITS_ACK) begin
                     next_state = IOX_WDATA;
                  end
               end
               IOX_RDATA: begin
                  if (bit_cnt == IOX_BITS_LAST) begin
                     // step to partner now so the next byte is ready
                     next_cur_sel = {cur_sel[2:1], ~cur_sel[0]};
                  end else if (bit_cnt == IOX_BITS_ACK) begin
                     // a nack releases sda but keeps the read open, so a repeated start can re-point
                     if (!master_nack) begin
                        next_tx_byte = bus.rd_data;
                        next_tx_drive = 1'b1;
                     end
                  end else if (!master_nack) begin
                     next_tx_byte = {tx_byte[6:0], 1'b0};
                     next_tx_drive = 1'b1;
                  end
               end
               default: begin
               end
            endcase
         end
      end
   end

   // engine registers
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         state <= IOX_IDLE;
         scl_q <= 1'b1;
         sda_q <= 1'b1;
         shift <= 8'h00;
         bit_cnt <= 4'h0;
         register_pointer <= IOX_PTR_RESET;
         cur_sel <= 3'h0;
         tx_byte <= 8'h00;
         ack_drive <= 1'b0;
         tx_drive <= 1'b0;
         master_nack <= 1'b0;
      end else begin
         state <= next_state;
         scl_q <= next_scl_q;
         sda_q <= next_sda_q;
         shift <= next_shift;
         bit_cnt <= next_bit_cnt;
         register_pointer <= next_pointer;
         cur_sel <= next_cur_sel;
         tx_byte <= next_tx_byte;
         ack_drive <= next_ack_drive;
         tx_drive <= next_tx_drive;
         master_nack <= next_master_nack;
      end
   end

   // open drain: only ever pull low
   assign sda_out = 1'b0;
   assign sda_oe = ack_drive | (tx_drive & ~tx_byte[7]);
endmodule // iox_top

// File: bench/iox_top_asserts.sv
// property checker bound to the expander top
`timescale 1ns/100ps
module iox_top_asserts (
   // clock and reset
   input wire logic clock,
   input wire logic arst_n,
   // serial bus
   input wire logic scl_in,
   input wire logic sda_in,
   input wire logic sda_out,
   input wire logic sda_oe,
   // port pins
   input wire logic [15:0] gpio_pin_out,
   input wire logic [15:0] gpio_pin_oe
);
   default clocking cb @(posedge clock); endclocking
   default disable iff (!arst_n);
   // no transfer fits before the first edge after release
   reset_image_a: assert property (!$past(arst_n) |-> gpio_pin_out == 16'hffff && gpio_pin_oe == 16'h0000)
      else $error("pins left reset image early");
   drive_capture_a: assert property (!$stable(gpio_pin_out) |-> $past(scl_in) && $past(sda_oe))
      else $error("drive level loaded outside acked slot");
   dir_capture_a: assert property (!$stable(gpio_pin_oe) |-> $past(scl_in) && $past(sda_oe))
      else $error("direction loaded outside acked slot");
   one_target_a: assert property (!(!$stable(gpio_pin_out) && !$stable(gpio_pin_oe)))
      else $error("one byte changed two registers");
   sda_change_a: assert property ($changed(sda_oe) |-> !scl_in)
      else $error("sda moved while scl high");
   open_drain_a: assert property (sda_out == 1'b0)
      else $error("sda driven high");
   idle_release_a: assert property ((scl_in && sda_in) [*8] |=> !sda_oe)
      else $error("sda held on idle bus");
   // a long run of zero data bits still ends well inside the bound
   sda_bounded_a: assert property (sda_oe |-> ##[1:200] !sda_oe)
      else $error("sda held too long");
endmodule // iox_top_asserts

bind iox_top iox_top_asserts i_iox_top_asserts (.clock(clock), .arst_n(arst_n), .scl_in(scl_in), .sda_in(sda_in),
   .sda_out(sda_out), .sda_oe(sda_oe), .gpio_pin_out(gpio_pin_out), .gpio_pin_oe(gpio_pin_oe));

// File: bench/iox_master.sv
// behavioural i2c bus master for the expander bench
`timescale 1ns/100ps
module iox_master (
   // clock
   input wire logic clock,
   // wired sda level, pull-up included
   input wire logic sda_line,
   // lines driven by the master
   output logic scl,
   output logic sda_m
);
   // bus idles released, pulled high
   initial begin
      scl = 1'b1;
      sda_m = 1'b1;
   end
   task automatic wt(input int n);
      repeat (n) @(posedge clock);
   endtask
   // sda only moves while scl is low, two clocks clear of each edge
   task automatic bit_x(input logic b, output logic r);
      wt(2);
      sda_m <= b;
      wt(3);
      scl <= 1'b1;
      wt(4);
      r = sda_line;
      scl <= 1'b0;
   endtask
   // start is cond(1,0), stop is cond(0,1)
   task automatic cond(input logic a, input logic b);
      wt(2);
      sda_m <= a;
      wt(3);
      scl <= 1'b1;
      wt(4);
      sda_m <= b;
      wt(4);
      scl <= b;
   endtask
   // eight bits msb first, then the acknowledge slot
   task automatic xfer(input logic [7:0] d, input logic last, output logic [7:0] q, output logic ack);
      for (int i = 7; i >= 0; i--) begin
         bit_x(d[i], q[i]);
      end
      bit_x(last, ack);
   endtask
endmodule // iox_master

// File: bench/tb_top.sv
// self-checking bench of the sixteen-bit expander
`timescale 1ns/100ps
module tb_top;
   logic clock = 1'b0;
   logic arst_n = 1'b0;
   logic strap_low = 1'b0;
   logic strap_high = 1'b0;
   logic [15:0] ext = 16'h0000;
   logic scl, sda_m, sda_out, sda_oe;
   logic [15:0] pin_in, pin_out, pin_oe;
   int err_total = 0;
   int tests_run = 0;
   wire sda_line = sda_m & ~sda_oe;
   // a pin shows its own driver where enabled, else the far-side level
   assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext);
   always #5 clock = ~clock;
   iox_top i_iox_top (.clock(clock), .arst_n(arst_n), .addr_strap_low(strap_low), .addr_strap_high(strap_high),
      .scl_in(scl), .sda_in(sda_line), .sda_out(sda_out), .sda_oe(sda_oe), .gpio_pin_in(pin_in),
      .gpio_pin_out(pin_out), .gpio_pin_oe(pin_oe));
   iox_master i_iox_master (.clock(clock), .sda_line(sda_line), .scl(scl), .sda_m(sda_m));
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      tests_run++;
      if (got !== exp) begin
         err_total++;
         $display("[ERR] %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic end_of_test();
      $display("tests_run %0d err_total %0d", tests_run, err_total);
      if (err_total == 0 && tests_run > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask
   // address byte from the straps, low strap as lsb
   function automatic logic [7:0] dev(input logic rd);
      return {7'h74 | {5'h00, strap_high, strap_low}, rd};
   endfunction
   task automatic wreg(input logic [7:0] cmd, input logic [15:0] d, input int n);
      logic [7:0] q;
      logic a;
      i_iox_master.cond(1'b1, 1'b0);
      i_iox_master.xfer(dev(1'b0), 1'b1, q, a);
      chk({15'h0000, a}, 16'h0000);
      i_iox_master.xfer(cmd, 1'b1, q, a);
      for (int i = 0; i < n; i++) begin
         i_iox_master.xfer(d[8*i+:8], 1'b1, q, a);
      end
      i_iox_master.cond(1'b0, 1'b1);
   endtask
   // two-byte read on the stored pointer, no command byte
   task automatic rd(output logic [15:0] q);
      logic a;
      i_iox_master.cond(1'b1, 1'b0);
      i_iox_master.xfer(dev(1'b1), 1'b1, q[7:0], a);
      i_iox_master.xfer(8'hff, 1'b0, q[7:0], a);
      i_iox_master.xfer(8'hff, 1'b1, q[15:8], a);
      i_iox_master.cond(1'b0, 1'b1);
   endtask
   task automatic t_defaults();
      logic [15:0] q;
      logic [47:0] exp = 48'hffff_0000_ffff;
      chk(pin_out, 16'hffff);
      chk(pin_oe, 16'h0000);
      for (int c = 1; c < 4; c++) begin
         wreg(8'(2 * c), 16'h0000, 0);
         rd(q);
         chk(q, exp[48-16*c+:16]);
      end
   endtask
   task automatic t_write();
      logic [15:0] q;
      wreg(8'h02, 16'h3ca5, 2);
      wreg(8'h06, 16'hf000, 2);
      chk(pin_out, 16'h3ca5);
      chk(pin_oe, 16'h0fff);
      wreg(8'hf3, 16'h0000, 0);
      rd(q);
      chk(q, 16'ha53c);
      rd(q);
      chk(q, 16'ha53c);
   endtask
   task automatic t_input();
      logic [15:0] q;
      ext <= 16'h5a96;
      wreg(8'h05, 16'h00ff, 1);
      wreg(8'h00, 16'h0000, 1);
      chk(pin_out, 16'h3ca5);
      wreg(8'h00, 16'h0000, 0);
      rd(q);
      chk(q, 16'ha3a5);
   endtask
   // odd passes flip one address bit and must be ignored
   task automatic t_addr();
      logic [7:0] q;
      logic a;
      for (int s = 0; s < 8; s++) begin
         {strap_high, strap_low} <= 2'(s >> 1);
         i_iox_master.wt(2);
         i_iox_master.cond(1'b1, 1'b0);
         i_iox_master.xfer(dev(1'b0) ^ {6'h00, s[0], 1'b0}, 1'b1, q, a);
         i_iox_master.cond(1'b0, 1'b1);
         chk({15'h0000, a}, {15'h0000, s[0]});
      end
   endtask
   task automatic t_restart();
      logic [15:0] q;
      logic a;
      wreg(8'h03, 16'h0000, 0);
      i_iox_master.cond(1'b1, 1'b0);
      i_iox_master.xfer(dev(1'b1), 1'b1, q[7:0], a);
      i_iox_master.xfer(8'hff, 1'b1, q[7:0], a);
      i_iox_master.cond(1'b1, 1'b0);
      i_iox_master.xfer(dev(1'b1), 1'b1, q[15:8], a);
      i_iox_master.xfer(8'hff, 1'b1, q[15:8], a);
      i_iox_master.cond(1'b0, 1'b1);
      chk(q, 16'ha53c);
      rd(q);
      chk(q, 16'h3ca5);
   endtask
   initial begin
      repeat (10) @(posedge clock);
      arst_n <= 1'b1;
      repeat (2) @(posedge clock);
      t_defaults();
      t_write();
      t_input();
      t_addr();
      t_restart();
      end_of_test();
   end
   // whole sequence needs under ten thousand clocks
   initial begin
      repeat (60000) @(posedge clock);
      err_total++;
      end_of_test();
   end
endmodule // tb_top
